// ===== pllcc_top.v
/*
   Loop and clock-driver control register with an AXI4-Lite slave port.
   The 40-bit control word is split over two words and applied only when
   both halves have been written. Decoded fields drive the analog controls.
   Assumes a single-clock system; lock and phase inputs are asynchronous.
*/
// Operation
// - Five-byte word applies only when fully written
// - Bit 39 powers down converter, output floats
// - Bit 33 band-gap off; ten ms resettle
// - Bit 32 picks internal driver current resistor
// - Bits 31:29 add weighted rising surge
// - Bits 28:26 add weighted falling surge
// - Bit 25 drives lock detect on pin
// - Bit 24 selects status or lead/lag meaning
// - Bit 23 divider off, reference feeds core
// - Bits 22:21 pick divide by 1,2,4,8
// - Bit 20 powers down clock driver
// - Bits 19:18 select clock driver source
// - Bit 17 removes all edge surge current
// - Bit 16 bypasses divider for core clock
// - Bits 15:12 reference divider equals field+1
// - Bits 11:8 oscillator divider equals field+1
// - Bit 5 sets charge-pump polarity
// - Bit 4 fully powers down charge pump
// - Bit 3 powers down pump output only
// - Bits 2:0 scale pump current field+1
`timescale 1ns/1ps
`default_nettype none
`include "pllcc_consts.vh"

module pllcc_top
#(
   parameter [20:0] BG_SETTLE_CYCLES = `PLLCC_BG_SETTLE_MS * `PLLCC_CLK_KHZ
)
(
   input  wire         aclk,
   input  wire         aresetn,
   input  wire [7:0]   s_axi_awaddr,
   input  wire         s_axi_awvalid,
   output reg          s_axi_awready,
   input  wire [31:0]  s_axi_wdata,
   input  wire [3:0]   s_axi_wstrb,
   input  wire         s_axi_wvalid,
   output reg          s_axi_wready,
   output reg  [1:0]   s_axi_bresp,
   output reg          s_axi_bvalid,
   input  wire         s_axi_bready,
   input  wire [7:0]   s_axi_araddr,
   input  wire         s_axi_arvalid,
   output reg          s_axi_arready,
   output reg  [31:0]  s_axi_rdata,
   output reg  [1:0]   s_axi_rresp,
   output reg          s_axi_rvalid,
   input  wire         s_axi_rready,
   input  wire         loop_locked,
   input  wire         osc_lags_ref,
   input  wire         osc_leads_ref,
   output reg          dac_power_down,
   output reg          dac_output_oe,
   output reg          bandgap_power_down,
   output reg          bandgap_ready,
   output reg          driver_internal_resistor,
   output reg          driver_current_resistor_pin_en,
   output reg  [8:0]   rise_surge_current,
   output reg  [8:0]   fall_surge_current,
   output reg          lock_pin_out,
   output reg          lock_pin_oe,
   output reg          rf_divider_enable,
   output reg  [3:0]   rf_divide_ratio,
   output reg          driver_enable,
   output reg  [1:0]   driver_source,
   output reg  [1:0]   core_clock_source,
   output reg  [4:0]   ref_divide_ratio,
   output reg  [4:0]   osc_divide_ratio,
   output reg          pump_running,
   output reg          pump_output_enable,
   output reg          pump_raise,
   output reg          pump_lower,
   output reg  [3:0]   pump_current_scale
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   reg  [31:0] ctrl_lo;
   reg  [7:0]  ctrl_hi;
   reg  [31:0] shadow_lo;
   reg  [7:0]  shadow_hi;
   reg         lo_staged;
   reg         hi_staged;
   reg  [20:0] bg_count;

   reg         aw_got;
   reg         w_got;
   reg  [7:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;

   wire [39:0] ctrl = {ctrl_hi, ctrl_lo};
   wire [2:0]  pin_sync;
   wire        locked_s = pin_sync[0];
   wire        lag_s    = pin_sync[1];
   wire        lead_s   = pin_sync[2];

   // ----------------------------------------------------------------------
   // Asynchronous analog status inputs
   // ----------------------------------------------------------------------
   pllcc_sync u_sync
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({osc_leads_ref, osc_lags_ref, loop_locked}),
      .sync_out (pin_sync)
   );

   // ----------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------
   // A half is staged only when every byte of it is present; a partial
   // write cannot corrupt the word and is answered with an error.
   wire do_write = aw_got && w_got && !s_axi_bvalid;
   wire lo_ok    = do_write && (aw_addr == `PLLCC_ADDR_LO) &&
                   (w_strb == `PLLCC_STRB_FULL);
   wire hi_ok    = do_write && (aw_addr == `PLLCC_ADDR_HI) && w_strb[0];
   wire commit   = (lo_ok || lo_staged) && (hi_ok || hi_staged);

   // ----------------------------------------------------------------------
   // AXI write channels, one transaction at a time
   // ----------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PLLCC_RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
      end
      else
      begin
         // Address and data are taken in either order
         if (s_axi_awready && s_axi_awvalid)
         begin
            s_axi_awready <= 1'b0;
            aw_got        <= 1'b1;
            aw_addr       <= s_axi_awaddr;
         end
         else if (!aw_got && !s_axi_bvalid)
            s_axi_awready <= 1'b1;

         if (s_axi_wready && s_axi_wvalid)
         begin
            s_axi_wready <= 1'b0;
            w_got        <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end
         else if (!w_got && !s_axi_bvalid)
            s_axi_wready <= 1'b1;

         // Response once both halves of the request are held
         if (do_write)
         begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (lo_ok || hi_ok) ? `PLLCC_RESP_OKAY : `PLLCC_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Control word staging and commit
   // ----------------------------------------------------------------------
   // Reserved bits are masked on store, so a host that breaks the zero
   // convention still reads back zeros there.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_lo   <= `PLLCC_RESET_LO;
         ctrl_hi   <= `PLLCC_RESET_HI;
         shadow_lo <= 32'h0000_0000;
         shadow_hi <= 8'h00;
         lo_staged <= 1'b0;
         hi_staged <= 1'b0;
      end
      else
      begin
         if (lo_ok)
            shadow_lo <= w_data & `PLLCC_MASK_LO;
         if (hi_ok)
            shadow_hi <= w_data[7:0] & `PLLCC_MASK_HI;
         if ((lo_ok || hi_ok) && commit)
         begin
            ctrl_lo   <= lo_ok ? (w_data & `PLLCC_MASK_LO) : shadow_lo;
            ctrl_hi   <= hi_ok ? (w_data[7:0] & `PLLCC_MASK_HI) : shadow_hi;
            lo_staged <= 1'b0;
            hi_staged <= 1'b0;
         end
         else
         begin
            if (lo_ok)
               lo_staged <= 1'b1;
            if (hi_ok)
               hi_staged <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // AXI read channel
   // ----------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `PLLCC_RESP_OKAY;
      end
      else if (s_axi_arready && s_axi_arvalid)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `PLLCC_RESP_OKAY;
         case (s_axi_araddr)
            `PLLCC_ADDR_LO:
               s_axi_rdata <= ctrl_lo;
            `PLLCC_ADDR_HI:
               s_axi_rdata <= {24'h00_0000, ctrl_hi};
            `PLLCC_ADDR_STATUS:
               s_axi_rdata <= {26'h000_0000, lead_s, lag_s, locked_s,
                               bandgap_ready, hi_staged, lo_staged};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `PLLCC_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else
         s_axi_arready <= 1'b1;
   end

   // ----------------------------------------------------------------------
   // Band-gap settle timer
   // ----------------------------------------------------------------------
   // Ready is withheld until the reference has had its full settle time
   // after power-up; a short power-down restarts the whole wait.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bg_count      <= 21'h00_0000;
         bandgap_ready <= 1'b0;
      end
      else if (ctrl[`PLLCC_B_BG_PD])
      begin
         bg_count      <= 21'h00_0000;
         bandgap_ready <= 1'b0;
      end
      else if (bg_count < BG_SETTLE_CYCLES)
      begin
         bg_count      <= bg_count + 21'h00_0001;
         bandgap_ready <= 1'b0;
      end
      else
         bandgap_ready <= 1'b1;
   end

   // ----------------------------------------------------------------------
   // Surge current sums
   // ----------------------------------------------------------------------
   wire [8:0] rise_extra = (ctrl[`PLLCC_B_RISE_HI]  ? `PLLCC_RISE_W_HI  : 9'h000) +
                           (ctrl[`PLLCC_B_RISE_MID] ? `PLLCC_RISE_W_MID : 9'h000) +
                           (ctrl[`PLLCC_B_RISE_LO]  ? `PLLCC_RISE_W_LO  : 9'h000);
   wire [8:0] fall_extra = (ctrl[`PLLCC_B_FALL_HI]  ? `PLLCC_FALL_W_HI  : 9'h000) +
                           (ctrl[`PLLCC_B_FALL_MID] ? `PLLCC_FALL_W_MID : 9'h000) +
                           (ctrl[`PLLCC_B_FALL_LO]  ? `PLLCC_FALL_W_LO  : 9'h000);

   // ----------------------------------------------------------------------
   // Pump gating
   // ----------------------------------------------------------------------
   // Quick power-down keeps the pump biased but silences its output, so
   // the loop recovers fast; full power-down stops everything.
   wire pump_out_on = !ctrl[`PLLCC_B_PUMP_PD] && !ctrl[`PLLCC_B_PUMP_QPD];
   wire want_raise  = ctrl[`PLLCC_B_PUMP_POL] ? lead_s : lag_s;
   wire want_lower  = ctrl[`PLLCC_B_PUMP_POL] ? lag_s : lead_s;

   // ----------------------------------------------------------------------
   // Registered decode of the applied word onto the analog controls
   // ----------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dac_power_down                 <= 1'b0;
         dac_output_oe                  <= 1'b0;
         bandgap_power_down             <= 1'b0;
         driver_internal_resistor       <= 1'b0;
         driver_current_resistor_pin_en <= 1'b0;
         rise_surge_current             <= 9'h000;
         fall_surge_current             <= 9'h000;
         lock_pin_out                   <= 1'b0;
         lock_pin_oe                    <= 1'b0;
         rf_divider_enable              <= 1'b0;
         rf_divide_ratio                <= 4'h0;
         driver_enable                  <= 1'b0;
         driver_source                  <= 2'h0;
         core_clock_source              <= `PLLCC_CLK_DIV_OUT;
         ref_divide_ratio               <= 5'h00;
         osc_divide_ratio               <= 5'h00;
         pump_running                   <= 1'b0;
         pump_output_enable             <= 1'b0;
         pump_raise                     <= 1'b0;
         pump_lower                     <= 1'b0;
         pump_current_scale             <= 4'h0;
      end
      else
      begin
         dac_power_down     <= ctrl[`PLLCC_B_DAC_PD];
         dac_output_oe      <= !ctrl[`PLLCC_B_DAC_PD];
         bandgap_power_down <= ctrl[`PLLCC_B_BG_PD];
         driver_internal_resistor       <= ctrl[`PLLCC_B_DRV_INT_R];
         driver_current_resistor_pin_en <= !ctrl[`PLLCC_B_DRV_INT_R];

         // Slew-off wins over every surge bit, the base values included
         if (ctrl[`PLLCC_B_SLEW_OFF])
         begin
            rise_surge_current <= 9'h000;
            fall_surge_current <= 9'h000;
         end
         else
         begin
            rise_surge_current <= `PLLCC_RISE_W_BASE + rise_extra;
            fall_surge_current <= `PLLCC_FALL_W_BASE + fall_extra;
         end

         // Pin floats unless lock detect is enabled
         lock_pin_oe <= ctrl[`PLLCC_B_LOCK_EN];
         if (!ctrl[`PLLCC_B_LOCK_EN])
            lock_pin_out <= 1'b0;
         else if (ctrl[`PLLCC_B_LOCK_MODE])
            lock_pin_out <= lag_s;
         else
            lock_pin_out <= !locked_s;

         rf_divider_enable <= !ctrl[`PLLCC_B_RFDIV_PD];
         rf_divide_ratio   <= 4'h1 << ctrl[`PLLCC_F_RFDIV_HI:`PLLCC_F_RFDIV_LO];

         // Divider power-down routes the reference around it entirely
         if (ctrl[`PLLCC_B_RFDIV_PD])
            core_clock_source <= `PLLCC_CLK_ALT_REF;
         else if (ctrl[`PLLCC_B_CLK_BYPASS])
            core_clock_source <= `PLLCC_CLK_DIV_IN;
         else
            core_clock_source <= `PLLCC_CLK_DIV_OUT;

         driver_enable <= !ctrl[`PLLCC_B_DRV_PD];
         driver_source <= ctrl[`PLLCC_F_DRVSEL_HI:`PLLCC_F_DRVSEL_LO];

         ref_divide_ratio <= {1'b0, ctrl[`PLLCC_F_REFDIV_HI:`PLLCC_F_REFDIV_LO]} + 5'h01;
         osc_divide_ratio <= {1'b0, ctrl[`PLLCC_F_OSCDIV_HI:`PLLCC_F_OSCDIV_LO]} + 5'h01;

         pump_running       <= !ctrl[`PLLCC_B_PUMP_PD];
         pump_output_enable <= pump_out_on;
         pump_raise         <= pump_out_on && want_raise;
         pump_lower         <= pump_out_on && want_lower;
         pump_current_scale <= {1'b0, ctrl[`PLLCC_F_PUMP_HI:`PLLCC_F_PUMP_LO]} + 4'h1;
      end
   end

endmodule

`default_nettype wire

// ===== pllcc_consts.vh
/*
   Constants for the loop and clock-driver control block: register offsets,
   field positions, reset values, surge weights and timing counts.
   Assumes inclusion by bare name from the design files that need them.
*/
`ifndef PLLCC_CONSTS_VH
`define PLLCC_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PLLCC_ADDR_LO       8'h00
`define PLLCC_ADDR_HI       8'h04
`define PLLCC_ADDR_STATUS   8'h08

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define PLLCC_RESET_LO      32'h0078_0000
`define PLLCC_RESET_HI      8'h00
`define PLLCC_MASK_LO       32'hFFFF_FF3F
`define PLLCC_MASK_HI       8'h83
`define PLLCC_STRB_FULL     4'hF

// ----------------------------------------------------------------------
// Field positions inside the 40-bit control word
// ----------------------------------------------------------------------
`define PLLCC_B_DAC_PD      39
`define PLLCC_B_BG_PD       33
`define PLLCC_B_DRV_INT_R   32
`define PLLCC_B_RISE_HI     31
`define PLLCC_B_RISE_MID    30
`define PLLCC_B_RISE_LO     29
`define PLLCC_B_FALL_HI     28
`define PLLCC_B_FALL_MID    27
`define PLLCC_B_FALL_LO     26
`define PLLCC_B_LOCK_EN     25
`define PLLCC_B_LOCK_MODE   24
`define PLLCC_B_RFDIV_PD    23
`define PLLCC_F_RFDIV_HI    22
`define PLLCC_F_RFDIV_LO    21
`define PLLCC_B_DRV_PD      20
`define PLLCC_F_DRVSEL_HI   19
`define PLLCC_F_DRVSEL_LO   18
`define PLLCC_B_SLEW_OFF    17
`define PLLCC_B_CLK_BYPASS  16
`define PLLCC_F_REFDIV_HI   15
`define PLLCC_F_REFDIV_LO   12
`define PLLCC_F_OSCDIV_HI   11
`define PLLCC_F_OSCDIV_LO   8
`define PLLCC_B_PUMP_POL    5
`define PLLCC_B_PUMP_PD     4
`define PLLCC_B_PUMP_QPD    3
`define PLLCC_F_PUMP_HI     2
`define PLLCC_F_PUMP_LO     0

// ----------------------------------------------------------------------
// Surge current weights in units of 0.05 mA
// ----------------------------------------------------------------------
`define PLLCC_RISE_W_HI     9'h098
`define PLLCC_RISE_W_MID    9'h04C
`define PLLCC_RISE_W_LO     9'h026
`define PLLCC_RISE_W_BASE   9'h098
`define PLLCC_FALL_W_HI     9'h06C
`define PLLCC_FALL_W_MID    9'h036
`define PLLCC_FALL_W_LO     9'h01B
`define PLLCC_FALL_W_BASE   9'h051

// ----------------------------------------------------------------------
// Core clock source codes
// ----------------------------------------------------------------------
`define PLLCC_CLK_DIV_OUT   2'h0
`define PLLCC_CLK_DIV_IN    2'h1
`define PLLCC_CLK_ALT_REF   2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PLLCC_BG_SETTLE_MS  10
`define PLLCC_CLK_KHZ       125000
`define PLLCC_SYNC_BITS     3

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define PLLCC_RESP_OKAY     2'h0
`define PLLCC_RESP_SLVERR   2'h2

`endif

// ===== pllcc_sync.v
/*
   Three-stage input synchroniser for asynchronous analog status lines.
   Assumes inputs may change at any time relative to aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module pllcc_sync
(
   input  wire         aclk,
   input  wire         aresetn,
   input  wire [2:0]   async_in,
   output reg  [2:0]   sync_out
);

   reg [2:0] stage1;
   reg [2:0] stage2;
   reg [2:0] stage3;

   // ----------------------------------------------------------------------
   // Per-bit chain; a change counts once stages two and three agree
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1)
      begin : g_bit
         always @(posedge aclk)
         begin
            if (!aresetn)
            begin
               stage1[i]   <= 1'b0;
               stage2[i]   <= 1'b0;
               stage3[i]   <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               stage1[i] <= async_in[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
               if (stage2[i] == stage3[i])
                  sync_out[i] <= stage3[i];   // Filters a single-cycle glitch
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ===== pllcc_top_unused_guard.v
`timescale 1ns/1ps

// ===== pllcc_loop_model.sv
/* Loop phase detector model feeding lock and lead/lag lines.
   Assumes the bench picks the loop state through phase. */
`timescale 1ns/1ps
`default_nettype none
module pllcc_loop_model
(
   input wire logic       aclk,
   input wire logic [1:0] phase,
   output logic           loop_locked,
   output logic           osc_lags_ref,
   output logic           osc_leads_ref
);
   // ----------------
   // Detector lines
   // ----------------
   // Quiet until the first edge so the synchroniser never sees unknowns
   initial {loop_locked, osc_lags_ref, osc_leads_ref} = 3'h0;
   // 0 locked, 1 lagging, 2 leading, 3 slipping with no clear sign
   always @(posedge aclk)
      {loop_locked, osc_lags_ref, osc_leads_ref} <= {phase == 2'h0, phase == 2'h1, phase == 2'h2};
endmodule
`default_nettype wire

// ===== pllcc_top_chk.sv
/* Concurrent checks on decoded outputs and the write answer.
   Assumes it is bound into pllcc_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pllcc_top_chk #(parameter [20:0] BG_SETTLE_CYCLES = 21'h000014)
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       dac_power_down,
   input wire logic       dac_output_oe,
   input wire logic [8:0] rise_surge_current,
   input wire logic [8:0] fall_surge_current,
   input wire logic       lock_pin_out,
   input wire logic       lock_pin_oe,
   input wire logic       rf_divider_enable,
   input wire logic [3:0] rf_divide_ratio,
   input wire logic [1:0] core_clock_source,
   input wire logic       pump_running,
   input wire logic       pump_output_enable,
   input wire logic       pump_raise,
   input wire logic       pump_lower
);
   // ----------------
   // Properties
   // ----------------
   // Outputs need one edge after reset before they show the word; checks wait three
   logic [1:0] up;
   wire        ok = up == 2'h3;
   always @(posedge aclk) up <= aresetn ? (ok ? up : up + 2'h1) : 2'h0;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
   sequence s_wr; s_aw and (s_axi_wvalid && s_axi_wready); endsequence
   a_write_answer: assert property (s_wr |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
   a_dac_float: assert property (ok |-> dac_output_oe == !dac_power_down) else $error("dac enable wrong");
   a_surge_floor: assert property (ok |-> (rise_surge_current == 9'h000 ? fall_surge_current == 9'h000
      : rise_surge_current >= 9'h098 && fall_surge_current >= 9'h051)) else $error("surge wrong");
   a_lock_quiet: assert property (ok && !lock_pin_oe |-> !lock_pin_out) else $error("lock pin active");
   a_ratio_onehot: assert property (ok |-> $onehot(rf_divide_ratio)) else $error("ratio not 1 2 4 8");
   a_alt_path: assert property (ok && !rf_divider_enable |-> core_clock_source == 2'h2) else $error("alt path");
   a_pump_off: assert property (ok && !pump_running |-> !pump_output_enable) else $error("pump buffer on");
   a_buf_quiet: assert property (ok && !pump_output_enable |-> !pump_raise && !pump_lower)
      else $error("pump out");
endmodule
bind pllcc_top pllcc_top_chk #(.BG_SETTLE_CYCLES(BG_SETTLE_CYCLES)) pllcc_top_chk_inst (.*);
`default_nettype wire

// ===== tb.sv
/* Bench: register traffic, decoded outputs and loop states.
   Assumes design, checker and loop model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ----------------
   // Bench
   // ----------------
   logic        aclk = 1'b0;
   logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, q;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  phase, rsp;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, loop_locked;
   wire         osc_lags_ref, osc_leads_ref, dac_power_down, dac_output_oe, bandgap_power_down, bandgap_ready;
   wire         driver_internal_resistor, driver_current_resistor_pin_en, lock_pin_out, lock_pin_oe;
   wire         rf_divider_enable, driver_enable, pump_running, pump_lower, pump_output_enable, pump_raise;
   wire [1:0]   s_axi_bresp, s_axi_rresp, driver_source, core_clock_source;
   wire [31:0]  s_axi_rdata;
   wire [8:0]   rise_surge_current, fall_surge_current;
   wire [3:0]   rf_divide_ratio, pump_current_scale;
   wire [4:0]   ref_divide_ratio, osc_divide_ratio;
   integer      err_count, total_checks, cyc;
   // Short settle count keeps the band-gap wait inside the run
   pllcc_top #(.BG_SETTLE_CYCLES(21'h000014)) pllcc_top_inst (.*);
   pllcc_loop_model pllcc_loop_model_inst (.*);
   initial forever #4 aclk = ~aclk;
   task chk(input string n, input logic [39:0] e, input logic [39:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Each channel is dropped only at the edge that takes it
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic got;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
      got = 1'b0;
      while (!got)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         got = w ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         rsp = w ? s_axi_bresp : s_axi_rresp;
      end
      {s_axi_bready, s_axi_rready} <= 2'h0;
   endtask
   task wr40(input logic [7:0] hi, input logic [31:0] lo);
      bus(1'b1, 8'h04, {24'h0, hi}, 4'hF);
      chk("bresp", 2'h0, rsp);
      bus(1'b1, 8'h00, lo, 4'hF);
      chk("bresp", 2'h0, rsp);
      repeat (2) @(posedge aclk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      bus(1'b0, a, 32'h0, 4'h0);
      chk("rdata", e, q);
      chk("rresp", r, rsp);
   endtask
   // Loop state needs six edges to show: model, three stages, sync_out and the decode register
   task ph(input logic [1:0] v, input logic pin, input logic rs, input logic lw);
      @(posedge aclk);
      phase <= v;
      repeat (8) @(posedge aclk);
      chk("lock", {1'b1, pin}, {lock_pin_oe, lock_pin_out});
      chk("raise", rs, pump_raise);
      chk("lower", lw, pump_lower);
   endtask
   task t_defaults;
      repeat (30) @(posedge aclk);
      rd(8'h00, 32'h0078_0000, 2'h0);
      chk("div", 4'h8, rf_divide_ratio);
      chk("drv", 3'h4, {driver_source, driver_enable});
      chk("lock", 2'h0, {lock_pin_oe, lock_pin_out});
      chk("surge", {9'h098, 9'h051}, {rise_surge_current, fall_surge_current});
      chk("bg", 1'b1, bandgap_ready);
      chk("rpin", 1'b1, driver_current_resistor_pin_en);
   endtask
   task t_pair;
      bus(1'b1, 8'h00, 32'hAA25_F027, 4'hF);
      repeat (3) @(posedge aclk);
      chk("half", 4'h8, rf_divide_ratio);
      rd(8'h08, 32'h0000_000D, 2'h0);
      bus(1'b1, 8'h04, 32'h0000_0001, 4'hF);
      repeat (2) @(posedge aclk);
      chk("div", 4'h2, rf_divide_ratio);
      chk("surge", {9'h156, 9'h087}, {rise_surge_current, fall_surge_current});
      chk("drv", 4'h7, {driver_source, driver_enable, driver_internal_resistor});
      chk("rpin", 1'b0, driver_current_resistor_pin_en);
      chk("core", 2'h1, core_clock_source);
      chk("nm", {5'h10, 5'h01}, {ref_divide_ratio, osc_divide_ratio});
      chk("scale", 4'h8, pump_current_scale);
      ph(2'h0, 1'b0, 1'b0, 1'b0);
      ph(2'h3, 1'b1, 1'b0, 1'b0);
      ph(2'h1, 1'b1, 1'b0, 1'b1);
      wr40(8'h01, 32'hAB25_F007);
      ph(2'h1, 1'b1, 1'b1, 1'b0);
      ph(2'h2, 1'b0, 1'b0, 1'b1);
      wr40(8'h01, 32'hAB25_F00F);
      ph(2'h2, 1'b0, 1'b0, 1'b0);
      chk("run", 2'h2, {pump_running, pump_output_enable});
   endtask
   task t_off;
      wr40(8'h83, 32'hFFFF_FF3F);
      chk("dac", 2'h2, {dac_power_down, dac_output_oe});
      chk("bg", 2'h2, {bandgap_power_down, bandgap_ready});
      chk("surge", 18'h0, {rise_surge_current, fall_surge_current});
      chk("alt", 3'h2, {rf_divider_enable, core_clock_source});
      chk("pump", 1'b0, pump_running);
      rd(8'h04, 32'h0000_0083, 2'h0);
      bus(1'b1, 8'h00, 32'h0, 4'h3);
      chk("part", 2'h2, rsp);
      bus(1'b1, 8'h08, 32'h0, 4'hF);
      chk("ro", 2'h2, rsp);
      rd(8'h0C, 32'h0, 2'h2);
      rd(8'h00, 32'hFFFF_FF3F, 2'h0);
   endtask
   // Hang guard: the run needs well under a thousand cycles
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         final_report;
      end
   end
   initial
   begin
      {err_count, total_checks, cyc} = 0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, phase} = 54'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_defaults;
      t_pair;
      t_off;
      final_report;
   end
endmodule
`default_nettype wire
